//--- hw/exs_defs.svh
// constants of the exception sequencer: vectors, addresses, reset values
// assumes a 32-bit longword memory port and an 8-bit vector number
`ifndef EXS_DEFS_SVH
`define EXS_DEFS_SVH

// vector numbers
`define EXS_VEC_RST_PC 8'h00
`define EXS_VEC_RST_SP 8'h01
`define EXS_VEC_GEN_ILL 8'h04
`define EXS_VEC_SLOT_ILL 8'h06
`define EXS_VEC_CPU_AE 8'h09
`define EXS_VEC_DMA_AE 8'h0A
`define EXS_VEC_NMI 8'h0B
`define EXS_VEC_UBRK 8'h0C

// reset fetch addresses
`define EXS_RST_PC_ADDR 32'h0000_0000
`define EXS_RST_SP_ADDR 32'h0000_0004

// reset values and mask levels
`define EXS_VECTOR_BASE_RST 32'h0000_0000
`define EXS_MASK_RST 4'hF
`define EXS_NMI_MASK 4'hF
`define EXS_UBRK_MASK 4'hF
`define EXS_STATUS_IMASK_LSB 4
`define EXS_LWORD 32'h0000_0004

// pending slots, index 0 highest
`define EXS_P_CPU_AE 0
`define EXS_P_DMA_AE 1
`define EXS_P_NMI 2
`define EXS_P_UBRK 3
`define EXS_P_INTC 4
`define EXS_P_TRAP 5
`define EXS_P_GEN_ILL 6
`define EXS_P_SLOT_ILL 7
`define EXS_NSRC 8
`define EXS_ASYNC_MASK 8'h1F

`endif

//--- hw/exs_mem_port.sv
// longword memory port: one read or write per start, held until ack
// assumes the memory holds its answer until the cycle it acks
`timescale 1ns/1ns
module exs_mem_port
  import exs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire logic we_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  output logic done_o,
  output logic [31:0] rdata_o,
  output exs_mem_s mem_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i
);

  exs_mp_s s_q;
  exs_mp_s s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (!s_q.busy && start_i) begin
      s_d.busy = 1'b1;
      s_d.bus.req = 1'b1;
      s_d.bus.we = we_i;
      s_d.bus.addr = addr_i;
      s_d.bus.wdata = wdata_i;
    end else if (s_q.bus.req && mem_ack_i) begin
      s_d.busy = 1'b0;
      s_d.bus.req = 1'b0;
      s_d.done = 1'b1;
      s_d.rdata = mem_rdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done_o = s_q.done;
  assign rdata_o = s_q.rdata;
  assign mem_o = s_q.bus;

  req_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_q.bus.req && !mem_ack_i |=> s_q.bus.req && $stable(s_q.bus.addr))
    else $error("memory request dropped before ack");

endmodule

//--- hw/exs_pkg.sv
// types of the exception sequencer
// assumes exs_defs.svh supplies the numeric constants
package exs_pkg;

  typedef enum logic [2:0] {
    ST_RST_PC = 3'b000,
    ST_RST_SP = 3'b001,
    ST_IDLE = 3'b010,
    ST_PUSH_SR = 3'b011,
    ST_PUSH_PC = 3'b100,
    ST_VEC = 3'b101
  } exs_state_e;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } exs_mem_s;

  typedef struct packed {
    logic busy;
    logic done;
    logic [31:0] rdata;
    exs_mem_s bus;
  } exs_mp_s;

  typedef struct packed {
    exs_state_e st;
    logic go;
    logic [7:0] pend;
    logic [7:0] vec;
    logic [7:0] tvec;
    logic [7:0] ivec;
    logic [3:0] ilvl;
    logic is_int;
    logic [3:0] new_mask;
    logic [31:0] status_word;
    logic [31:0] pc;
    logic [31:0] sp;
    logic [31:0] vector_base_reg;
    logic [3:0] mask;
    logic mask_we;
    logic pc_load;
    logic sp_load;
    logic stall;
    logic abort;
    logic int_ack;
  } exs_top_s;

endpackage

//--- hw/exs_prio.sv
// fixed priority picker over the pending exception sources
// assumes bit 0 of the pending vector is the most urgent
`timescale 1ns/1ns
module exs_prio
  import exs_pkg::*;
(
  input wire logic [7:0] pend_i,
  output logic [7:0] grant_o
);

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pick
      if (i == 0) begin : g_top
        assign grant_o[i] = pend_i[i];
      end else begin : g_low
        assign grant_o[i] = pend_i[i] & ~(|pend_i[i-1:0]);
      end
    end
  endgenerate

endmodule

//--- hw/exs_sequencer.sv
// exception sequencer top: arbitration and entry sequence of the core
// assumes pipeline, interrupt controller and memory all share clk_i
`timescale 1ns/1ns
`include "exs_defs.svh"
module exs_sequencer
  import exs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic dec_valid_i,
  input wire logic dec_undef_i,
  input wire logic dec_pc_write_i,
  input wire logic dec_in_slot_i,
  input wire logic insn_done_i,
  input wire logic trap_exec_i,
  input wire logic [7:0] trap_imm_i,
  input wire logic cpu_addr_err_i,
  input wire logic dma_addr_err_i,
  input wire logic nmi_i,
  input wire logic ubrk_i,
  input wire logic intc_req_i,
  input wire logic [7:0] intc_vec_i,
  input wire logic [3:0] intc_lvl_i,
  input wire logic [31:0] status_word_reg_i,
  input wire logic [31:0] ret_pc_i,
  input wire logic [31:0] general_reg_fifteen_i,
  input wire logic vector_base_reg_we_i,
  input wire logic [31:0] vector_base_reg_wdata_i,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  output exs_mem_s mem_o,
  output logic stall_o,
  output logic pc_load_o,
  output logic [31:0] pc_val_o,
  output logic sp_load_o,
  output logic [31:0] sp_val_o,
  output logic [31:0] vector_base_reg_o,
  output logic mask_we_o,
  output logic [3:0] mask_o,
  output logic bus_abort_o,
  output logic intc_ack_o,
  output logic [7:0] exc_vec_o
);

  exs_top_s s_q;
  exs_top_s s_d;
  logic [7:0] grant;
  logic [7:0] set;
  logic int_ok;
  logic start_ok;
  logic mp_start;
  logic mp_we;
  logic [31:0] mp_addr;
  logic [31:0] mp_wdata;
  logic mp_done;
  logic [31:0] mp_rdata;

  exs_prio u_prio (
    .pend_i(s_q.pend),
    .grant_o(grant)
  );

  exs_mem_port u_mp (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .start_i(mp_start),
    .we_i(mp_we),
    .addr_i(mp_addr),
    .wdata_i(mp_wdata),
    .done_o(mp_done),
    .rdata_o(mp_rdata),
    .mem_o(mem_o),
    .mem_ack_i(mem_ack_i),
    .mem_rdata_i(mem_rdata_i)
  );

  // interrupt accepted only above the current mask
  assign int_ok = dec_valid_i && intc_req_i &&
    (intc_lvl_i > status_word_reg_i[`EXS_STATUS_IMASK_LSB+3:`EXS_STATUS_IMASK_LSB]);

  // new pending events
  always_comb begin
    set = 8'h00;
    set[`EXS_P_CPU_AE] = cpu_addr_err_i;
    set[`EXS_P_DMA_AE] = dma_addr_err_i;
    set[`EXS_P_NMI] = nmi_i;
    set[`EXS_P_UBRK] = ubrk_i;
    set[`EXS_P_INTC] = int_ok;
    set[`EXS_P_TRAP] = trap_exec_i;
    set[`EXS_P_GEN_ILL] = dec_valid_i && !dec_in_slot_i && dec_undef_i;
    set[`EXS_P_SLOT_ILL] = dec_valid_i && dec_in_slot_i &&
      (dec_undef_i || dec_pc_write_i);
  end

  // instruction exceptions go at once, the rest at instruction end
  assign start_ok = (|(s_q.pend & ~`EXS_ASYNC_MASK)) ||
    ((|(s_q.pend & `EXS_ASYNC_MASK)) && insn_done_i);

  // memory access of each state
  always_comb begin
    mp_start = s_q.go;
    mp_we = 1'b0;
    mp_addr = 32'h0000_0000;
    mp_wdata = 32'h0000_0000;
    case (s_q.st)
      ST_RST_PC: begin
        mp_addr = `EXS_RST_PC_ADDR;
      end
      ST_RST_SP: begin
        mp_addr = `EXS_RST_SP_ADDR;
      end
      ST_PUSH_SR: begin
        mp_we = 1'b1;
        mp_addr = s_q.sp - `EXS_LWORD;
        mp_wdata = s_q.status_word;
      end
      ST_PUSH_PC: begin
        mp_we = 1'b1;
        mp_addr = s_q.sp - (`EXS_LWORD + `EXS_LWORD);
        mp_wdata = s_q.pc;
      end
      ST_VEC: begin
        mp_addr = s_q.vector_base_reg + {22'h00_0000, s_q.vec, 2'b00};
      end
      default: begin
        mp_start = 1'b0;
      end
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.go = 1'b0;
    s_d.mask_we = 1'b0;
    s_d.pc_load = 1'b0;
    s_d.sp_load = 1'b0;
    s_d.int_ack = 1'b0;
    s_d.abort = cpu_addr_err_i || dma_addr_err_i;
    if (int_ok) begin
      s_d.ivec = intc_vec_i;
      s_d.ilvl = intc_lvl_i;
    end
    if (trap_exec_i) begin
      s_d.tvec = trap_imm_i;
    end
    if (vector_base_reg_we_i) begin
      s_d.vector_base_reg = vector_base_reg_wdata_i;
    end
    s_d.pend = s_q.pend | set;
    case (s_q.st)
      ST_RST_PC: begin
        if (mp_done) begin
          s_d.pc = mp_rdata;
          s_d.st = ST_RST_SP;
          s_d.go = 1'b1;
        end
      end
      ST_RST_SP: begin
        if (mp_done) begin
          s_d.sp = mp_rdata;
          s_d.vector_base_reg = `EXS_VECTOR_BASE_RST;
          s_d.mask = `EXS_MASK_RST;
          s_d.mask_we = 1'b1;
          s_d.pc_load = 1'b1;
          s_d.sp_load = 1'b1;
          s_d.stall = 1'b0;
          s_d.st = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (start_ok) begin
          // granted bit cleared, a fresh event of that source still wins
          s_d.pend = (s_q.pend & ~grant) | set;
          s_d.is_int = 1'b0;
          s_d.new_mask = s_q.mask;
          if (grant[`EXS_P_CPU_AE]) begin
            s_d.vec = `EXS_VEC_CPU_AE;
          end else if (grant[`EXS_P_DMA_AE]) begin
            s_d.vec = `EXS_VEC_DMA_AE;
          end else if (grant[`EXS_P_NMI]) begin
            s_d.vec = `EXS_VEC_NMI;
            s_d.is_int = 1'b1;
            s_d.new_mask = `EXS_NMI_MASK;
          end else if (grant[`EXS_P_UBRK]) begin
            s_d.vec = `EXS_VEC_UBRK;
            s_d.is_int = 1'b1;
            s_d.new_mask = `EXS_UBRK_MASK;
          end else if (grant[`EXS_P_INTC]) begin
            s_d.vec = s_q.ivec;
            s_d.is_int = 1'b1;
            s_d.new_mask = s_q.ilvl;
            s_d.int_ack = 1'b1;
          end else if (grant[`EXS_P_TRAP]) begin
            s_d.vec = s_q.tvec;
          end else if (grant[`EXS_P_GEN_ILL]) begin
            s_d.vec = `EXS_VEC_GEN_ILL;
          end else begin
            s_d.vec = `EXS_VEC_SLOT_ILL;
          end
          s_d.status_word = status_word_reg_i;
          s_d.pc = ret_pc_i;
          s_d.sp = general_reg_fifteen_i;
          s_d.stall = 1'b1;
          s_d.st = ST_PUSH_SR;
          s_d.go = 1'b1;
        end
      end
      ST_PUSH_SR: begin
        if (mp_done) begin
          s_d.st = ST_PUSH_PC;
          s_d.go = 1'b1;
        end
      end
      ST_PUSH_PC: begin
        if (mp_done) begin
          s_d.st = ST_VEC;
          s_d.go = 1'b1;
        end
      end
      ST_VEC: begin
        if (mp_done) begin
          s_d.pc = mp_rdata;
          s_d.sp = s_q.sp - (`EXS_LWORD + `EXS_LWORD);
          s_d.pc_load = 1'b1;
          s_d.sp_load = 1'b1;
          s_d.mask_we = s_q.is_int;
          s_d.mask = s_q.is_int ? s_q.new_mask : s_q.mask;
          s_d.stall = 1'b0;
          s_d.st = ST_IDLE;
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
  end

  // reset pin low holds everything, its release starts the vector fetch
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q <= '0;
      s_q.st <= ST_RST_PC;
      s_q.go <= 1'b1;
      s_q.stall <= 1'b1;
      s_q.mask <= `EXS_MASK_RST;
      s_q.vector_base_reg <= `EXS_VECTOR_BASE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign stall_o = s_q.stall;
  assign pc_load_o = s_q.pc_load;
  assign pc_val_o = s_q.pc;
  assign sp_load_o = s_q.sp_load;
  assign sp_val_o = s_q.sp;
  assign vector_base_reg_o = s_q.vector_base_reg;
  assign mask_we_o = s_q.mask_we;
  assign mask_o = s_q.mask;
  assign bus_abort_o = s_q.abort;
  assign intc_ack_o = s_q.int_ack;
  assign exc_vec_o = s_q.vec;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  prio_cpu_ae_a: assert property (
    s_q.st == ST_IDLE && start_ok && s_q.pend[`EXS_P_CPU_AE]
    |=> s_q.vec == `EXS_VEC_CPU_AE && s_q.st == ST_PUSH_SR)
    else $error("cpu address error not served first");

  reset_start_a: assert property (
    $past(rstn_i) == 1'b0 |-> s_q.st == ST_RST_PC && mp_start && !mp_we)
    else $error("reset fetch did not start on release");

  wait_insn_a: assert property (
    s_q.st == ST_IDLE && !insn_done_i && s_q.pend != 8'h00 &&
    (s_q.pend & ~`EXS_ASYNC_MASK) == 8'h00 |=> s_q.st == ST_IDLE)
    else $error("async exception started mid instruction");

  trap_go_a: assert property (
    s_q.st == ST_IDLE && trap_exec_i |=> ##1 s_q.st != ST_IDLE || s_q.pc_load)
    else $error("trap did not start after execution");

  slot_ill_a: assert property (
    dec_valid_i && dec_in_slot_i && dec_pc_write_i |=> s_q.pend[`EXS_P_SLOT_ILL])
    else $error("pc write in delay slot not flagged");

  gen_ill_a: assert property (
    dec_valid_i && !dec_in_slot_i && dec_undef_i |=> s_q.pend[`EXS_P_GEN_ILL])
    else $error("undefined opcode not flagged");

  reset_sp_addr_a: assert property (
    s_q.st == ST_RST_SP && mp_start |-> mp_addr == `EXS_RST_SP_ADDR)
    else $error("reset stack pointer read from wrong address");

  reset_init_a: assert property (
    s_q.st == ST_RST_SP && mp_done |=> vector_base_reg_o == `EXS_VECTOR_BASE_RST &&
    mask_o == `EXS_MASK_RST && mask_we_o && pc_load_o && !stall_o)
    else $error("reset did not initialise base and mask");

  push_pc_a: assert property (
    s_q.st == ST_PUSH_PC && mp_start |-> mp_we && mp_wdata == s_q.pc &&
    mp_addr == s_q.sp - 32'h0000_0008)
    else $error("program counter pushed to wrong slot");

  mask_keep_a: assert property (
    s_q.st == ST_VEC && mp_done && !s_q.is_int |=> !mask_we_o && $stable(mask_o))
    else $error("mask changed on non interrupt entry");

  vec_addr_a: assert property (
    s_q.st == ST_VEC && mp_start |->
    mp_addr == vector_base_reg_o + {22'h00_0000, s_q.vec, 2'b00})
    else $error("vector address miscomputed");

  nmi_mask_a: assert property (
    s_q.st == ST_VEC && mp_done && s_q.vec == `EXS_VEC_NMI |=> mask_o == `EXS_NMI_MASK)
    else $error("nmi mask level wrong");

  abort_a: assert property (
    cpu_addr_err_i |=> bus_abort_o)
    else $error("bus cycle not ended on address error");

  reset_done_c: cover property (s_q.st == ST_RST_SP && mp_done);
  int_entry_c: cover property (intc_ack_o ##[1:40] pc_load_o);
  trap_entry_c: cover property (s_q.st == ST_IDLE && grant[`EXS_P_TRAP] && start_ok);
  slot_entry_c: cover property (s_q.st == ST_IDLE && grant[`EXS_P_SLOT_ILL] && start_ok);

endmodule

//--- tb/exs_mem_model.sv
// memory model on the far side of the sequencer's longword port
// assumes one request at a time, held until acknowledged
`timescale 1ns/1ns
module exs_mem_model
  import exs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire exs_mem_s mem_i,
  input wire logic [3:0] lat_i,
  output logic ack_o,
  output logic [31:0] rdata_o
);
  logic [3:0] cnt_q;
  logic [31:0] la[$];
  logic lw[$];
  logic [31:0] ld[$];
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_o <= 1'b0;
      cnt_q <= 4'h0;
      rdata_o <= 32'h0000_0000;
      la.delete();
      lw.delete();
      ld.delete();
    end else if (mem_i.req && !ack_o && cnt_q >= lat_i) begin
      ack_o <= 1'b1;
      rdata_o <= mem_i.addr ^ 32'h1234_5670;
      cnt_q <= 4'h0;
      la.push_back(mem_i.addr);
      lw.push_back(mem_i.we);
      ld.push_back(mem_i.wdata);
    end else begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      cnt_q <= (mem_i.req && !ack_o) ? cnt_q + 4'h1 : 4'h0;
    end
  end
endmodule

//--- tb/testbench.sv
// self-checking bench of the exception sequencer
// assumes the memory model answers every longword access
`timescale 1ns/1ns
module testbench;
  import exs_pkg::*;
  localparam logic [31:0] stack_v = 32'h0000_2000;
  localparam logic [31:0] status_v = 32'h0000_0030;
  localparam logic [31:0] rpc_v = 32'h0000_0100;
  localparam logic [31:0] vb_v = 32'h0000_4000;
  logic clk_i, rstn_i, intc_req_i, ack;
  logic [10:0] pl;
  logic [7:0] intc_vec_i, exc_vec_o;
  logic [3:0] intc_lvl_i, lat, mask_o;
  logic [31:0] rdata, pc_val_o, sp_val_o, vector_base_reg_o;
  exs_mem_s mem_o;
  logic stall_o, pc_load_o, sp_load_o, mask_we_o, bus_abort_o, intc_ack_o;
  int errors, checked;

  exs_sequencer DUT (.clk_i(clk_i), .rstn_i(rstn_i), .dec_valid_i(pl[6]), .dec_undef_i(pl[8]),
    .dec_pc_write_i(pl[9]), .dec_in_slot_i(pl[10]), .insn_done_i(pl[5]), .trap_exec_i(pl[0]),
    .trap_imm_i(8'h21), .cpu_addr_err_i(pl[1]), .dma_addr_err_i(pl[2]), .nmi_i(pl[3]),
    .ubrk_i(pl[4]), .intc_req_i(intc_req_i), .intc_vec_i(intc_vec_i), .intc_lvl_i(intc_lvl_i),
    .status_word_reg_i(status_v), .ret_pc_i(rpc_v), .general_reg_fifteen_i(stack_v),
    .vector_base_reg_we_i(pl[7]), .vector_base_reg_wdata_i(vb_v),
    .mem_ack_i(ack), .mem_rdata_i(rdata), .mem_o(mem_o), .stall_o(stall_o),
    .pc_load_o(pc_load_o), .pc_val_o(pc_val_o), .sp_load_o(sp_load_o), .sp_val_o(sp_val_o),
    .vector_base_reg_o(vector_base_reg_o), .mask_we_o(mask_we_o), .mask_o(mask_o),
    .bus_abort_o(bus_abort_o),
    .intc_ack_o(intc_ack_o), .exc_vec_o(exc_vec_o));

  exs_mem_model mem (.clk_i(clk_i), .rstn_i(rstn_i), .mem_i(mem_o), .lat_i(lat), .ack_o(ack),
    .rdata_o(rdata));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  function automatic logic [31:0] mv(input logic [31:0] a);
    return a ^ 32'h1234_5670;
  endfunction

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic pulse(input logic [10:0] m);
    @(posedge clk_i);
    pl <= m;
    @(posedge clk_i);
    pl <= '0;
  endtask

  task automatic finish_insn;
    pulse(11'h040);
    pulse(11'h020);
  endtask

  task automatic quiet(input string n);
    repeat (4) @(posedge clk_i);
    #1;
    chk(n, 0, stall_o);
  endtask

  task automatic entry(input logic [7:0] v, input logic mw, input logic [3:0] mk,
      input logic [31:0] vb, input logic rst);
    int n;
    logic sm;
    logic [3:0] sv;
    logic [31:0] va;
    n = 0;
    sm = 0;
    sv = 0;
    va = vb + {22'h0, v, 2'b00};
    do begin
      @(posedge clk_i);
      #1;
      n++;
      if (mask_we_o === 1'b1) begin
        sm = 1;
        sv = mask_o;
      end
    end while (pc_load_o !== 1'b1 && n < 200);
    if (n >= 200) begin
      errors++;
      $display("MISMATCH pc load expected 1 seen %b", pc_load_o);
      give_verdict();
    end
    chk("mask write", mw, sm);
    chk("mask", mk, sv);
    chk("sp load", 1, sp_load_o);
    if (rst) begin
      chk("count", 2, mem.la.size());
      chk("pc addr", 0, mem.la[0]);
      chk("sp addr", 4, mem.la[1]);
      chk("pc", mv(0), pc_val_o);
      chk("sp", mv(4), sp_val_o);
    end else begin
      chk("count", 3, mem.la.size());
      chk("status addr", stack_v - 4, mem.la[0]);
      chk("status data", status_v, mem.ld[0]);
      chk("pc addr", stack_v - 8, mem.la[1]);
      chk("pc data", rpc_v, mem.ld[1]);
      chk("writes", 3'b110, {mem.lw[0], mem.lw[1], mem.lw[2]});
      chk("vec addr", va, mem.la[2]);
      chk("handler", mv(va), pc_val_o);
      chk("sp", stack_v - 8, sp_val_o);
      chk("vector", {24'h0, v}, exc_vec_o);
    end
    @(posedge clk_i);
    #1;
    chk("stall after", 0, stall_o);
    mem.la.delete();
    mem.lw.delete();
    mem.ld.delete();
  endtask

  task automatic t_reset;
    @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    #1;
    chk("req in reset", 0, mem_o.req);
    chk("stall in reset", 1, stall_o);
    @(posedge clk_i);
    rstn_i <= 1'b1;
    entry(8'h00, 1, 4'hF, 0, 1);
    chk("base", 0, vector_base_reg_o);
    $display("test reset done");
  endtask

  task automatic t_trap;
    lat <= 4'h3;
    pulse(11'h001);
    entry(8'h21, 0, 0, 0, 0);
    lat <= 4'h0;
    $display("test trap done");
  endtask

  task automatic t_ill;
    pulse(11'h240);
    quiet("branch outside slot");
    pulse(11'h140);
    entry(8'h04, 0, 0, 0, 0);
    pulse(11'h540);
    entry(8'h06, 0, 0, 0, 0);
    pulse(11'h640);
    entry(8'h06, 0, 0, 0, 0);
    $display("test illegal done");
  endtask

  task automatic t_aerr;
    pulse(11'h002);
    #1;
    chk("abort", 1, bus_abort_o);
    quiet("wait for insn end");
    finish_insn();
    entry(8'h09, 0, 0, 0, 0);
    pulse(11'h004);
    finish_insn();
    entry(8'h0A, 0, 0, 0, 0);
    $display("test address error done");
  endtask

  task automatic t_int;
    pulse(11'h080);
    #1;
    chk("base", vb_v, vector_base_reg_o);
    pulse(11'h008);
    finish_insn();
    #1;
    chk("nmi ack", 0, intc_ack_o);
    entry(8'h0B, 1, 4'hF, vb_v, 0);
    pulse(11'h010);
    finish_insn();
    entry(8'h0C, 1, 4'hF, vb_v, 0);
    @(posedge clk_i);
    intc_lvl_i <= 4'h3;
    intc_req_i <= 1'b1;
    finish_insn();
    quiet("masked request");
    @(posedge clk_i);
    intc_lvl_i <= 4'h5;
    finish_insn();
    #1;
    chk("intc ack", 1, intc_ack_o);
    entry(8'h48, 1, 4'h5, vb_v, 0);
    @(posedge clk_i);
    intc_req_i <= 1'b0;
    $display("test interrupt done");
  endtask

  task automatic t_prio;
    pulse(11'h00E);
    finish_insn();
    entry(8'h09, 0, 0, vb_v, 0);
    finish_insn();
    entry(8'h0A, 0, 0, vb_v, 0);
    finish_insn();
    entry(8'h0B, 1, 4'hF, vb_v, 0);
    $display("test priority done");
  endtask

  initial begin
    rstn_i = 1'b0;
    pl = '0;
    intc_req_i = 1'b0;
    intc_vec_i = 8'h48;
    intc_lvl_i = 4'h5;
    lat = 4'h0;
    errors = 0;
    checked = 0;
    t_reset();
    t_trap();
    t_ill();
    t_aerr();
    t_int();
    t_prio();
    t_reset();
    give_verdict();
  end
endmodule
